// *** pwc_defines.vh ***
// Register map, field positions, reset values and response codes for pwc_csr_bank.
// Assumes inclusion by bare name; definitions only.
`ifndef PWC_DEFINES_VH
`define PWC_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PWC_OFF_CMD        8'h88
`define PWC_OFF_PERF       8'h8c
`define PWC_OFF_POWER_MGMT_CTRL_STATUS      8'h90
`define PWC_OFF_CFGCMD     8'h94

// ------------------------------------------------------------
// Command register fields
// ------------------------------------------------------------
`define PWC_CMD_PM_BIT     19
`define PWC_CMD_WOL_BIT    18
`define PWC_CMD_RWP_BIT    6
`define PWC_CMD_PAUSE_BIT  5
`define PWC_CMD_RTE_BIT    4
`define PWC_CMD_DRT_HI     3
`define PWC_CMD_DRT_LO     2
`define PWC_CMD_SWI_BIT    1
`define PWC_CMD_UR_BIT     0
`define PWC_DRT_RESET      2'h1
`define PWC_DRT_32B        2'h0
`define PWC_DRT_64B        2'h1
`define PWC_DRT_SAF        2'h2

// ------------------------------------------------------------
// Performance counter fields
// ------------------------------------------------------------
`define PWC_PERF_LAT_HI    31
`define PWC_PERF_LAT_LO    16
`define PWC_PERF_DW_HI     7
`define PWC_PERF_DW_LO     0

// ------------------------------------------------------------
// Power management control/status fields
// ------------------------------------------------------------
`define PWC_PM_WAKE_EVENT_FLAG_BIT    15
`define PWC_PM_PMEEN_BIT   8
`define PWC_PM_POWER_STATE_FIELD_HI     1
`define PWC_PM_POWER_STATE_FIELD_LO     0
`define PWC_PM_DATA_SCALE_FIELD       2'h0
`define PWC_PM_DATA_SELECT_FIELD        4'h0

// ------------------------------------------------------------
// Config command word fields
// ------------------------------------------------------------
`define PWC_CFG_CAPMIR_BIT 20
`define PWC_CAP_PTR_PM     8'h44

// ------------------------------------------------------------
// AXI responses
// ------------------------------------------------------------
`define PWC_RESP_OKAY      2'h0
`define PWC_RESP_SLVERR    2'h2

`endif

// *** pwc_csr_bank.v ***
// Command, bus performance and power management registers with sleep/wake logic.
// Assumes an AXI4-Lite master on clk_sys; event inputs are pulses on clk_sys.
`include "pwc_defines.vh"
`default_nettype none

// Behaviour
// - Capability pointer zero when capability disabled
// - Mirror capability enable into config bit 20
// - PM mode wakes on magic, unicast, multicast
// - Setting wake mode enters sleep state
// - Sleep holds until wake, clear, reset
// - Wake mode accepts only magic frames
// - Pointer reset write restarts pattern pointer
// - Pause loaded from negotiation, software overridable
// - Threshold disabled means fixed 64 bytes
// - Drain field codes, resets to 01
// - Auto underrun recovery enable, resets 0
// - Latency tally adds read request clocks
// - Dword tally counts bus master dwords
// - Tallies read-only, cleared by reading
// - Wake flag sets regardless of enable
// - Write one clears flag, drops PME
// - PME only while wake signal enabled
// - Data scale and select read zero
// - Power state codes; unsupported writes discarded
module pwc_csr_bank #(
  parameter [3:0] PWR_SUPPORT = 4'hf
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        srst,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Straps and link status
  input  wire        pm_strap,
  input  wire        wol_strap,
  input  wire        aneg_done,
  input  wire        aneg_pause,
  // Frame match pulses
  input  wire        frame_magic,
  input  wire        frame_unicast,
  input  wire        frame_multicast,
  // Bus master activity
  input  wire        bm_read_busy,
  input  wire        bm_dword,
  // Controls out
  output reg         cap_ptr_zero,
  output reg  [7:0]  cap_ptr,
  output reg         sleep_state,
  output reg         wake_ptr_reset,
  output reg         pause_enable,
  output reg  [1:0]  rx_threshold_sel,
  output reg         rx_store_forward,
  output reg         software_interrupt_request,
  output reg         auto_underrun_recovery,
  output reg         pme_n
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Straps and negotiation lines arrive asynchronously
  reg [1:0] pm_s_r, wol_s_r, an_s_r, ap_s_r;
  reg       an_d_r;
  reg       strap_done_r;

  always @(posedge clk_sys) begin
    pm_s_r <= {pm_s_r[0], pm_strap};
    wol_s_r <= {wol_s_r[0], wol_strap};
    an_s_r <= {an_s_r[0], aneg_done};
    ap_s_r <= {ap_s_r[0], aneg_pause};
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg        pm_capability_enable_r;
  reg        lan_wake_mode_enable_r;
  reg        rx_threshold_enable_r;
  reg [1:0]  rx_drain_threshold_r;
  reg        pause_r;
  reg        swi_r;
  reg        ur_r;
  reg [15:0] read_latency_tally_r;
  reg [7:0]  dword_transfer_tally_r;
  reg        wake_event_flag_r;
  reg        wake_signal_enable_r;
  reg [1:0]  power_state_field_r;
  reg        asleep_r;

  // ------------------------------------------------------------
  // AXI handshake
  // ------------------------------------------------------------
  // Address and data held until both have arrived
  reg        aw_hold_r, w_hold_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire rd_go   = s_axi_arvalid & s_axi_arready;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // Exact word match; offsets are word aligned
  function reg_hit;
    input [7:0] a;
    input [7:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  // Unmapped offsets answer with an error response
  function mapped;
    input [7:0] a;
    begin
      mapped = reg_hit(a, `PWC_OFF_CMD) | reg_hit(a, `PWC_OFF_PERF) |
               reg_hit(a, `PWC_OFF_POWER_MGMT_CTRL_STATUS) | reg_hit(a, `PWC_OFF_CFGCMD);
    end
  endfunction

  // Register writes land as the response is raised
  wire wr_cmd  = wr_go & reg_hit(aw_addr_r, `PWC_OFF_CMD);
  wire wr_pm   = wr_go & reg_hit(aw_addr_r, `PWC_OFF_POWER_MGMT_CTRL_STATUS);
  // Reading the tallies clears them in the same cycle
  wire rd_perf = rd_go & reg_hit(s_axi_araddr, `PWC_OFF_PERF);

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PWC_RESP_OKAY;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_hold_r & ~aw_take & ~s_axi_bvalid;
      s_axi_wready <= ~w_hold_r & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_r) ? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte lanes for writes
  wire wb0 = w_strb_r[0];
  wire wb1 = w_strb_r[1];
  wire wb2 = w_strb_r[2];

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Unmapped offsets read as zero
  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (s_axi_araddr)
      `PWC_OFF_CMD: begin
        rd_nxt[`PWC_CMD_PM_BIT] = pm_capability_enable_r;
        rd_nxt[`PWC_CMD_WOL_BIT] = lan_wake_mode_enable_r;
        rd_nxt[`PWC_CMD_PAUSE_BIT] = pause_r;
        rd_nxt[`PWC_CMD_RTE_BIT] = rx_threshold_enable_r;
        rd_nxt[`PWC_CMD_DRT_HI:`PWC_CMD_DRT_LO] = rx_drain_threshold_r;
        rd_nxt[`PWC_CMD_SWI_BIT] = swi_r;
        rd_nxt[`PWC_CMD_UR_BIT] = ur_r;
      end
      `PWC_OFF_PERF: begin
        rd_nxt[`PWC_PERF_LAT_HI:`PWC_PERF_LAT_LO] = read_latency_tally_r;
        rd_nxt[`PWC_PERF_DW_HI:`PWC_PERF_DW_LO] = dword_transfer_tally_r;
      end
      `PWC_OFF_POWER_MGMT_CTRL_STATUS: begin
        rd_nxt[`PWC_PM_WAKE_EVENT_FLAG_BIT] = wake_event_flag_r;
        rd_nxt[14:13] = `PWC_PM_DATA_SCALE_FIELD;
        rd_nxt[12:9] = `PWC_PM_DATA_SELECT_FIELD;
        rd_nxt[`PWC_PM_PMEEN_BIT] = wake_signal_enable_r;
        rd_nxt[`PWC_PM_POWER_STATE_FIELD_HI:`PWC_PM_POWER_STATE_FIELD_LO] = power_state_field_r;
      end
      `PWC_OFF_CFGCMD: begin
        rd_nxt[`PWC_CFG_CAPMIR_BIT] = pm_capability_enable_r;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PWC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= mapped(s_axi_araddr) ? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Wake detection
  // ------------------------------------------------------------
  // Any frame class reported by the matcher
  wire frame_any = frame_magic | frame_unicast | frame_multicast;
  // Wake mode narrows wake frames to magic ones only
  wire wake_hit = lan_wake_mode_enable_r ? frame_magic :
                  (pm_capability_enable_r & frame_any);
  // Outside wake mode a wake frame counts without sleeping first
  wire wake_ok  = wake_hit & (asleep_r | ~lan_wake_mode_enable_r);
  // Only a 0 to 1 write of the mode bit enters sleep
  wire wol_wr   = wr_cmd & wb2;
  wire wol_set  = wol_wr & w_data_r[`PWC_CMD_WOL_BIT] & ~lan_wake_mode_enable_r;

  // ------------------------------------------------------------
  // Command register
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      strap_done_r <= 1'b0;
      pm_capability_enable_r <= 1'b0;
      lan_wake_mode_enable_r <= 1'b0;
      rx_threshold_enable_r <= 1'b0;
      rx_drain_threshold_r <= `PWC_DRT_RESET;
      pause_r <= 1'b0;
      swi_r <= 1'b0;
      ur_r <= 1'b0;
      an_d_r <= 1'b0;
      asleep_r <= 1'b0;
      wake_ptr_reset <= 1'b0;
    end else begin
      an_d_r <= an_s_r[1];
      strap_done_r <= 1'b1;
      // Straps sampled once, after the synchroniser settles
      if (~strap_done_r) begin
        pm_capability_enable_r <= pm_s_r[1];
        lan_wake_mode_enable_r <= wol_s_r[1];
      end
      // Negotiation edge loads pause; a software write overrides
      if (an_s_r[1] & ~an_d_r)
        pause_r <= ap_s_r[1];
      wake_ptr_reset <= wr_cmd & wb0 & w_data_r[`PWC_CMD_RWP_BIT];
      if (wr_cmd & wb0) begin
        pause_r <= w_data_r[`PWC_CMD_PAUSE_BIT];
        rx_threshold_enable_r <= w_data_r[`PWC_CMD_RTE_BIT];
        rx_drain_threshold_r <= w_data_r[`PWC_CMD_DRT_HI:`PWC_CMD_DRT_LO];
        swi_r <= w_data_r[`PWC_CMD_SWI_BIT];
        ur_r <= w_data_r[`PWC_CMD_UR_BIT];
      end
      if (wol_wr & strap_done_r)
        lan_wake_mode_enable_r <= w_data_r[`PWC_CMD_WOL_BIT];
      if (wol_set)
        asleep_r <= 1'b1;
      else if ((wol_wr & ~w_data_r[`PWC_CMD_WOL_BIT]) | (asleep_r & wake_hit))
        asleep_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Performance tallies
  // ------------------------------------------------------------
  // Tallies wrap; a read restarts from this cycle's activity
  always @(posedge clk_sys) begin
    if (srst) begin
      read_latency_tally_r <= 16'h0000;
      dword_transfer_tally_r <= 8'h00;
    end else if (rd_perf) begin
      read_latency_tally_r <= {15'h0000, bm_read_busy};
      dword_transfer_tally_r <= {7'h00, bm_dword};
    end else begin
      read_latency_tally_r <= read_latency_tally_r + {15'h0000, bm_read_busy};
      dword_transfer_tally_r <= dword_transfer_tally_r + {7'h00, bm_dword};
    end
  end

  // ------------------------------------------------------------
  // Power management control/status
  // ------------------------------------------------------------
  wire [1:0] power_state_field_wr = w_data_r[`PWC_PM_POWER_STATE_FIELD_HI:`PWC_PM_POWER_STATE_FIELD_LO];
  wire wake_event_flag_clr = wr_pm & wb1 & w_data_r[`PWC_PM_WAKE_EVENT_FLAG_BIT];

  always @(posedge clk_sys) begin
    if (srst) begin
      wake_event_flag_r <= 1'b0;
      wake_signal_enable_r <= 1'b0;
      power_state_field_r <= 2'h0;
    end else begin
      // Set wins over a clear in the same cycle
      if (wake_ok)
        wake_event_flag_r <= 1'b1;
      else if (wake_event_flag_clr)
        wake_event_flag_r <= 1'b0;
      if (wr_pm & wb1)
        wake_signal_enable_r <= w_data_r[`PWC_PM_PMEEN_BIT];
      if (wr_pm & wb0 & PWR_SUPPORT[power_state_field_wr])
        power_state_field_r <= power_state_field_wr;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      cap_ptr_zero <= 1'b1;
      cap_ptr <= 8'h00;
      sleep_state <= 1'b0;
      pause_enable <= 1'b0;
      rx_threshold_sel <= `PWC_DRT_64B;
      rx_store_forward <= 1'b0;
      software_interrupt_request <= 1'b0;
      auto_underrun_recovery <= 1'b0;
      pme_n <= 1'b1;
    end else begin
      cap_ptr_zero <= ~pm_capability_enable_r;
      cap_ptr <= pm_capability_enable_r ? `PWC_CAP_PTR_PM : 8'h00;
      sleep_state <= asleep_r;
      pause_enable <= pause_r;
      // Fixed 64 byte threshold while selection is off
      rx_threshold_sel <= rx_threshold_enable_r ? rx_drain_threshold_r : `PWC_DRT_64B;
      rx_store_forward <= rx_threshold_enable_r & (rx_drain_threshold_r == `PWC_DRT_SAF);
      software_interrupt_request <= swi_r;
      auto_underrun_recovery <= ur_r;
      pme_n <= ~(wake_event_flag_r & wake_signal_enable_r);
    end
  end

endmodule

`default_nettype wire

// *** pwc_csr_bank_sva.sv ***
// Checker for pwc_csr_bank: bus handshakes, wake and control outputs.
// Assumes binding to pwc_csr_bank; clk_sys rising edge, srst sync high.
`include "pwc_defines.vh"
`default_nettype none
module pwc_csr_bank_sva (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       srst,
  // Bus handshakes
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Events and controls
  input wire logic       frame_magic,
  input wire logic       frame_unicast,
  input wire logic       frame_multicast,
  input wire logic       cap_ptr_zero,
  input wire logic [7:0] cap_ptr,
  input wire logic       sleep_state,
  input wire logic       wake_ptr_reset,
  input wire logic [1:0] rx_threshold_sel,
  input wire logic       rx_store_forward,
  input wire logic       pme_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence bus_idle; s_axi_awready && s_axi_wready; endsequence
  sequence other_frame; sleep_state && !frame_magic && (frame_unicast || frame_multicast); endsequence
  a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after take");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before accept");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before accept");
  a_cap_ptr_value: assert property (cap_ptr == (cap_ptr_zero ? 8'h00 : `PWC_CAP_PTR_PM))
    else $error("capability pointer wrong");
  a_ptr_reset_pulse: assert property (wake_ptr_reset |=> !wake_ptr_reset)
    else $error("pointer reset longer than one cycle");
  a_magic_wakes: assert property (sleep_state && frame_magic |-> ##[1:3] !sleep_state)
    else $error("magic frame did not end sleep");
  a_other_ignored: assert property (bus_idle ##0 other_frame |=> sleep_state)
    else $error("non-magic frame ended sleep");
  a_store_fwd_code: assert property (rx_store_forward |-> rx_threshold_sel == `PWC_DRT_SAF)
    else $error("store and forward with wrong code");
  a_reset_values: assert property (disable iff (1'b0)
    srst |=> pme_n && rx_threshold_sel == `PWC_DRT_RESET)
    else $error("reset values wrong");
endmodule
bind pwc_csr_bank pwc_csr_bank_sva u_sva (.clk_sys, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .frame_magic, .frame_unicast, .frame_multicast,
  .cap_ptr_zero, .cap_ptr, .sleep_state, .wake_ptr_reset, .rx_threshold_sel,
  .rx_store_forward, .pme_n);
`default_nettype wire

// *** pwc_host_model.sv ***
// Host model: AXI4-Lite master making single register accesses.
// Assumes the pwc_csr_bank slave on clk_sys; the bench calls wr and rd.
`default_nettype none
module pwc_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Write side
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  // Read side
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
           s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  // Released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test_pwc_csr_bank.sv ***
// Bench for pwc_csr_bank: register map, wake flow, tallies and controls.
// Assumes pwc_host_model as bus master and the bound checker.
`include "pwc_defines.vh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_pwc_csr_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, srst = 1'b1, ptr_seen;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cap_ptr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rx_threshold_sel;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        cap_ptr_zero, sleep_state, wake_ptr_reset, pause_enable, rx_store_forward;
  logic        software_interrupt_request, auto_underrun_recovery, pme_n;
  logic        pm_strap = 1'b1, wol_strap = 1'b0, aneg_done = 1'b0, aneg_pause = 1'b0;
  logic        frame_magic = 1'b0, frame_unicast = 1'b0, frame_multicast = 1'b0;
  logic        bm_read_busy = 1'b0, bm_dword = 1'b0;
  int          fails = 0, num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) ptr_seen <= srst ? 1'b0 : (ptr_seen | wake_ptr_reset);
  pwc_csr_bank #(.PWR_SUPPORT(4'hb)) dut (.clk_sys, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_strap, .wol_strap, .aneg_done, .aneg_pause,
    .frame_magic, .frame_unicast, .frame_multicast, .bm_read_busy, .bm_dword, .cap_ptr_zero,
    .cap_ptr, .sleep_state, .wake_ptr_reset, .pause_enable, .rx_threshold_sel,
    .rx_store_forward, .software_interrupt_request, .auto_underrun_recovery, .pme_n);
  pwc_host_model host (.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // ------------------------------------------------------------
  // Access helpers
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    host.wr(a, d, 4'hf, r);
    `CHK("bresp", er, r)
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    host.rd(a, d, r);
    `CHK("rresp", er, r)
    `CHK("rdata", e, d)
  endtask
  // Frame bits: magic, unicast, multicast
  task automatic frame(input logic [2:0] f);
    @(posedge clk_sys) {frame_magic, frame_unicast, frame_multicast} <= f;
    @(posedge clk_sys) {frame_magic, frame_unicast, frame_multicast} <= 3'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rdc(`PWC_OFF_CMD, 32'h0008_0004);
    `CHK("cap_ptr", `PWC_CAP_PTR_PM, cap_ptr)
    rdc(`PWC_OFF_CFGCMD, 32'h0010_0000);
    rdc(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h0);
    rdc(8'h80, 32'h0, `PWC_RESP_SLVERR);
    wr(8'h80, 32'hffff_ffff, `PWC_RESP_SLVERR);
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 3; i++) begin
      wr(`PWC_OFF_CMD, 32'h10 | (i << 2));
      `CHK("drain_sel", i[1:0], rx_threshold_sel)
      `CHK("store_fwd", i == 2, rx_store_forward)
    end
    wr(`PWC_OFF_CMD, 32'h0);
    `CHK("fixed_sel", `PWC_DRT_64B, rx_threshold_sel)
    wr(`PWC_OFF_CMD, 32'h63);
    `CHK("swi", 1'b1, software_interrupt_request)
    `CHK("underrun", 1'b1, auto_underrun_recovery)
    `CHK("ptr_reset", 1'b1, ptr_seen)
    rdc(`PWC_OFF_CMD, 32'h0008_0023);
    wr(`PWC_OFF_CMD, 32'h4);
    `CHK("swi_clr", 1'b0, software_interrupt_request)
    `CHK("pause_sw", 1'b0, pause_enable)
    @(posedge clk_sys) {aneg_pause, aneg_done} <= 2'h3;
    repeat (6) @(posedge clk_sys);
    `CHK("pause_neg", 1'b1, pause_enable)
  endtask
  task automatic t_perf;
    @(posedge clk_sys) {bm_read_busy, bm_dword} <= 2'h3;
    repeat (3) @(posedge clk_sys);
    bm_dword <= 1'b0;
    repeat (2) @(posedge clk_sys);
    bm_read_busy <= 1'b0;
    rdc(`PWC_OFF_PERF, 32'h0005_0003);
    rdc(`PWC_OFF_PERF, 32'h0);
  endtask
  task automatic t_pwr;
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h3);
    rdc(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h3);
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h2);
    rdc(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h3);
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h0);
  endtask
  task automatic t_wake;
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h100);
    wr(`PWC_OFF_CMD, 32'h4_0004);
    `CHK("sleep", 1'b1, sleep_state)
    frame(3'h3);
    `CHK("sleep_other", 1'b1, sleep_state)
    frame(3'h4);
    `CHK("sleep_magic", 1'b0, sleep_state)
    `CHK("pme_on", 1'b0, pme_n)
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h100);
    rdc(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h8100);
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h8100);
    `CHK("pme_off", 1'b1, pme_n)
    rdc(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h100);
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h0);
    wr(`PWC_OFF_CMD, 32'h4);
    frame(3'h2);
    `CHK("pme_dis", 1'b1, pme_n)
    rdc(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h8000);
    wr(`PWC_OFF_POWER_MGMT_CTRL_STATUS, 32'h8000);
    wr(`PWC_OFF_CMD, 32'h4_0004);
    wr(`PWC_OFF_CMD, 32'h4);
    `CHK("sleep_clr", 1'b0, sleep_state)
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_ctrl();
    t_perf();
    t_pwr();
    t_wake();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
